// *** rtl/adc_parallel_host_port.sv ***
/*
 * Parallel host port: read of the conversion result in word or byte mode,
 * writes to control and shadow registers, busy and conversion handshake.
 * Assumes all pins synchronous to i_clk; data pins split into in/out/enable.
 */
// Contract
// R1: Data pins float except during result reads
// R2: Ten-bit words put zero on lines 0-1
// R3: Word mode makes shared pin data bit 8
// R4: Byte mode, enable low moves low byte
// R5: Enable high moves top nibble on lines 0-3
// R6: High-byte read shows channel id lines 4-6
// R7: Host writes zero on lines 4-7 high byte
// R8: Ten-bit low byte zeroes two lowest lines
// R9: Lines 9-11 used only in word mode
// R10: Busy rises after start falling edge
// R11: Busy falls once result is loaded; the code drops busy one clock before the result register loads
// R12: Tracking resumes on thirteenth clock edge
// R13: Conversion takes thirteen clocks plus tail
// R14: Free-running or burst master clock works
// R15: Start falling edge switches to hold
// R16: Start rising edge powers up after sleep
// R17: Write strobe with select loads register
// R18: Read strobe with select drives result
// R19: Host asserts select with every strobe
`timescale 1ns/10ps
module adc_parallel_host_port
	import host_port_pkg::*;
#(
	parameter int RES_BITS = 12
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_word_mode,
	input wire logic [7:0] i_data_lines_low,
	input wire logic i_shared_bit8_or_upper_enable,
	input wire logic [2:0] i_data_lines_upper,
	input wire logic i_conversion_start_n,
	input wire logic i_master_clock_in,
	input wire logic [RESULT_W-1:0] i_conv_result,
	input wire logic [CHAN_W-1:0] i_conv_chan,
	input wire logic i_auto_sleep,
	output logic [7:0] o_data_lines_low,
	output logic [7:0] o_data_lines_low_oe,
	output logic o_shared_bit8,
	output logic o_shared_bit8_oe,
	output logic [2:0] o_data_lines_upper,
	output logic [2:0] o_data_lines_upper_oe,
	output logic o_busy,
	output logic o_track_hold,
	output logic o_powered,
	output logic [11:0] o_control,
	output logic [11:0] o_shadow,
	output logic o_ctrl_write
);
	initial
	begin
		if (RES_BITS != 12 && RES_BITS != 10)
			$error("RES_BITS must be 10 or 12");
	end

	typedef struct packed {
		logic [11:0] result;
		logic [CHAN_W-1:0] chan;
		logic [11:0] control;
		logic [11:0] shadow;
		logic [11:0] wr_word;
		logic low_pending;
		logic wr_q;
		logic rd_q;
		logic [11:0] dout;
		logic [11:0] doe;
		logic strobe;
	} port_t;
	port_t st_ff, nxt_st;

	bus_in_t bus_in;
	sample_t raw_sample;
	sample_t loaded;
	logic load;
	logic upper_en;
	logic [11:0] rd_word;
	logic [11:0] wr_assembled;

	assign bus_in = '{cs_n: i_cs_n, rd_n: i_rd_n, wr_n: i_wr_n, word_mode: i_word_mode,
		data_in: {i_data_lines_upper, i_shared_bit8_or_upper_enable, i_data_lines_low}};
	assign raw_sample = '{result: i_conv_result, chan: i_conv_chan};
	// In byte mode the shared pin is an input only: the upper byte enable
	assign upper_en = !bus_in.word_mode && i_shared_bit8_or_upper_enable; // [R4]

	conv_sequencer u_seq (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_conversion_start_n(i_conversion_start_n),
		.i_master_clock_in(i_master_clock_in),
		.i_sample(raw_sample),
		.i_auto_sleep(i_auto_sleep),
		.o_busy(o_busy),
		.o_hold(o_track_hold),
		.o_powered(o_powered),
		.o_load(load),
		.o_loaded(loaded)
	);

	always_comb
	begin
		rd_word = st_ff.result;
		// Ten-bit parts carry the LSB on line 2 with two zero pads below
		if (RES_BITS == 10)
			rd_word = {st_ff.result[11:TEN_BIT_PAD], 2'b00}; // [R2] [R8]
	end

	always_comb
	begin
		wr_assembled = bus_in.data_in;
		if (!bus_in.word_mode)
		begin
			// Upper nibble uses lines 0-3; lines 4-7 are expected zero and dropped
			if (upper_en)
				wr_assembled = {bus_in.data_in[3:0], st_ff.wr_word[7:0]}; // [R5] [R7]
			else
				wr_assembled = {st_ff.wr_word[11:8], bus_in.data_in[7:0]}; // [R4]
		end
	end

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.wr_q = bus_in.wr_n;
		nxt_st.rd_q = bus_in.rd_n;
		nxt_st.strobe = 1'b0;
		if (load)
		begin
			nxt_st.result = loaded.result; // [R11]
			nxt_st.chan = loaded.chan;
		end
		// Host is trusted to frame every strobe with select
		if (!bus_in.cs_n && !bus_in.rd_n) // [R19]
		begin
			if (bus_in.word_mode)
			begin
				nxt_st.dout = rd_word; // [R18]
				nxt_st.doe = 12'hfff; // [R3] [R9]
			end
			else if (upper_en)
			begin
				nxt_st.dout = {4'h0, 1'b0, st_ff.chan, rd_word[11:8]}; // [R5] [R6]
				nxt_st.doe = 12'h0ff;
			end
			else
			begin
				nxt_st.dout = {4'h0, rd_word[7:0]}; // [R4] [R8]
				nxt_st.doe = 12'h0ff; // [R9]
			end
		end
		else
		begin
			nxt_st.doe = 12'h000; // [R1]
		end
		// Capture on the rising edge of the write strobe, when data is settled
		if (!bus_in.cs_n && bus_in.wr_n && !st_ff.wr_q) // [R17]
		begin
			nxt_st.wr_word = wr_assembled;
			// Byte mode: the low byte is staged until its upper nibble arrives
			if (!bus_in.word_mode && !upper_en)
				nxt_st.low_pending = 1'b1;
			else
			begin
				nxt_st.low_pending = 1'b0;
				nxt_st.strobe = 1'b1;
				// Top bit steers the word to control or shadow storage
				if (wr_assembled[11])
					nxt_st.control = wr_assembled; // [R17]
				else
					nxt_st.shadow = wr_assembled;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			st_ff <= '{result: '0, chan: '0, control: CTRL_RST, shadow: SHADOW_RST,
				wr_word: 12'h000, low_pending: 1'b0, wr_q: 1'b1, rd_q: 1'b1,
				dout: 12'h000, doe: 12'h000, strobe: 1'b0};
		else
			st_ff <= nxt_st;
	end

	assign o_data_lines_low = st_ff.dout[7:0];
	assign o_data_lines_low_oe = st_ff.doe[7:0];
	assign o_shared_bit8 = st_ff.dout[8];
	assign o_shared_bit8_oe = st_ff.doe[8] && i_word_mode; // [R3]
	assign o_data_lines_upper = st_ff.dout[11:9];
	assign o_data_lines_upper_oe = st_ff.doe[11:9]; // [R9]
	assign o_control = st_ff.control;
	assign o_shadow = st_ff.shadow;
	assign o_ctrl_write = st_ff.strobe;
endmodule // adc_parallel_host_port

// *** rtl/host_port_pkg.sv ***
/*
 * Constants and carrier types for the parallel host port of the converter.
 * Assumes one 250 MHz system clock; all pins sampled synchronously.
 */
package host_port_pkg;
	localparam int DATA_W = 12;
	localparam int RESULT_W = 12;
	localparam int CHAN_W = 3;
	localparam int CONV_CYCLES = 13;
	localparam int TAIL_NS = 8;
	localparam int CLK_NS = 4;
	localparam int TAIL_CYCLES = (TAIL_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOW_BYTE_W = 8;
	localparam int HIGH_NIBBLE_W = 4;
	localparam int CHAN_ID_LSB = 4;
	localparam int TEN_BIT_PAD = 2;
	localparam logic [11:0] CTRL_RST = 12'h000;
	localparam logic [11:0] SHADOW_RST = 12'h000;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic word_mode;
		logic [DATA_W-1:0] data_in;
	} bus_in_t;

	typedef struct packed {
		logic [DATA_W-1:0] data_out;
		logic [DATA_W-1:0] data_oe;
	} bus_out_t;

	typedef struct packed {
		logic [RESULT_W-1:0] result;
		logic [CHAN_W-1:0] chan;
	} sample_t;
endpackage

// *** rtl/conv_sequencer.sv ***
/*
 * Conversion timing: counts master clock rising edges after the start edge,
 * releases hold on the 13th, then loads the result and drops busy.
 * Assumes the master clock pin is sampled in the system clock domain.
 */
`timescale 1ns/10ps
module conv_sequencer
	import host_port_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_conversion_start_n,
	input wire logic i_master_clock_in,
	input wire sample_t i_sample,
	input wire logic i_auto_sleep,
	output logic o_busy,
	output logic o_hold,
	output logic o_powered,
	output logic o_load,
	output sample_t o_loaded
);
	typedef enum logic [1:0] {IDLE, CONVERT, TAIL} conv_state_t;
	typedef struct packed {
		conv_state_t state;
		logic [4:0] edges;
		logic [3:0] tail;
		logic start_q;
		logic mclk_q;
		logic busy;
		logic hold;
		logic powered;
		logic load;
		sample_t sample;
	} seq_t;
	seq_t st_ff, nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.start_q = i_conversion_start_n;
		nxt_st.mclk_q = i_master_clock_in;
		nxt_st.load = 1'b0;
		// A rising start edge wakes the core out of auto power-down
		if (i_conversion_start_n && !st_ff.start_q)
			nxt_st.powered = 1'b1; // [R16]
		case (st_ff.state)
			IDLE:
			begin
				if (!i_conversion_start_n && st_ff.start_q && st_ff.powered)
				begin
					nxt_st.state = CONVERT;
					nxt_st.hold = 1'b1; // [R15]
					nxt_st.busy = 1'b1; // [R10]
					nxt_st.edges = 5'h00;
					nxt_st.sample = i_sample;
				end
			end
			CONVERT:
			begin
				// Bursty clock only advances on edges seen, so gaps just stretch time
				if (i_master_clock_in && !st_ff.mclk_q) // [R14]
				begin
					nxt_st.edges = st_ff.edges + 5'h01;
					if (st_ff.edges == 5'(CONV_CYCLES - 1)) // [R13]
					begin
						nxt_st.hold = 1'b0; // [R12]
						nxt_st.state = TAIL;
						nxt_st.tail = 4'(TAIL_CYCLES);
					end
				end
			end
			TAIL:
			begin
				if (st_ff.tail == 4'h1)
				begin
					nxt_st.load = 1'b1;
					nxt_st.busy = 1'b0; // [R11]
					nxt_st.state = IDLE;
					if (i_auto_sleep)
						nxt_st.powered = 1'b0;
				end
				nxt_st.tail = st_ff.tail - 4'h1;
			end
			default:
				nxt_st.state = IDLE;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			st_ff <= '{state: IDLE, edges: 5'h00, tail: 4'h0, start_q: 1'b1,
				mclk_q: 1'b0, busy: 1'b0, hold: 1'b0, powered: 1'b1,
				load: 1'b0, sample: '0};
		else
			st_ff <= nxt_st;
	end

	assign o_busy = st_ff.busy;
	assign o_hold = st_ff.hold;
	assign o_powered = st_ff.powered;
	assign o_load = st_ff.load;
	assign o_loaded = st_ff.sample;
endmodule // conv_sequencer

// *** tb/host_port_props.sv ***
/* Assertions on the host port pins.
   Assumes a bind onto the top module. */
`timescale 1ns/10ps
module host_port_props
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_word_mode,
	input wire logic i_conversion_start_n,
	input wire logic i_master_clock_in,
	input wire logic [7:0] o_data_lines_low_oe,
	input wire logic o_shared_bit8_oe,
	input wire logic [2:0] o_data_lines_upper_oe,
	input wire logic o_busy,
	input wire logic o_track_hold,
	input wire logic o_powered,
	input wire logic o_ctrl_write
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	logic [4:0] edges_ff;
	// Master clock rises seen while busy
	always_ff @(posedge i_clk)
		edges_ff <= o_busy ? edges_ff + 5'($rose(i_master_clock_in)) : 5'h00;
	a_bus_idle: assert property ((i_cs_n | i_rd_n) && $past(i_cs_n | i_rd_n) |->
		{o_data_lines_low_oe, o_shared_bit8_oe, o_data_lines_upper_oe} == 12'h000)
		else $error("pins driven while idle");
	a_word_read: assert property (!i_cs_n && !i_rd_n ##1
		!i_cs_n && !i_rd_n && i_word_mode |-> {o_data_lines_low_oe, o_shared_bit8_oe,
		o_data_lines_upper_oe} == 12'hfff) else $error("word read not driven");
	a_byte_lines: assert property (!i_word_mode && $past(!i_word_mode) |->
		{o_shared_bit8_oe, o_data_lines_upper_oe} == 4'h0) else $error("upper pins driven");
	a_busy_start: assert property ($fell(i_conversion_start_n) && !o_busy && o_powered
		|-> ##[1:2] o_busy) else $error("busy late");
	a_hold_start: assert property ($rose(o_busy) |-> o_track_hold)
		else $error("no hold at start");
	a_busy_fall: assert property ($fell(o_busy) |-> $past(o_track_hold, 3)
		&& !$past(o_track_hold, 2)) else $error("busy fall out of step with hold");
	a_conv_edges: assert property ($fell(o_busy) |-> edges_ff == 5'd13)
		else $error("conversion clock count wrong");
	a_write_pulse: assert property (!i_cs_n && i_wr_n && $past(!i_wr_n) && i_word_mode
		|=> o_ctrl_write) else $error("no write pulse");
endmodule // host_port_props
bind adc_parallel_host_port host_port_props host_port_props_inst (.*);

// *** tb/host_model.sv ***
/* Host side of the parallel bus: strobes, data drive, pin levels.
   Assumes pin order {upper, bit8, low}. */
`timescale 1ns/10ps
module host_model
(
	input wire logic i_clk,
	input wire logic [11:0] i_dev,
	input wire logic [11:0] i_dev_oe,
	output logic o_cs_n = 1'b1,
	output logic o_rd_n = 1'b1,
	output logic o_wr_n = 1'b1,
	output logic [11:0] o_pins
);
	logic [11:0] drv = 12'h000;
	logic [11:0] en = 12'h000;
	logic [11:0] last_ff = 12'h000;
	// An undriven pin flips each cycle so stale data never matches
	assign o_pins = i_dev_oe & i_dev | ~i_dev_oe & (en & drv | ~en & ~last_ff);
	always_ff @(posedge i_clk)
		last_ff <= o_pins;
	task automatic xfer(input logic wr, input logic [11:0] e, input logic [11:0] d,
		output logic [11:0] q);
		@(posedge i_clk);
		o_cs_n <= 1'b0;
		o_rd_n <= wr;
		o_wr_n <= !wr;
		en <= e;
		drv <= d;
		repeat (3) @(posedge i_clk);
		q = o_pins;
		o_rd_n <= 1'b1;
		o_wr_n <= 1'b1;
		@(posedge i_clk);
		o_cs_n <= 1'b1;
		en <= 12'h000;
		repeat (2) @(posedge i_clk);
	endtask
endmodule // host_model

// *** tb/test_adc_parallel_host_port.sv ***
/* Self-checking bench for the host port.
   Assumes the host model and the bound checker. */
`timescale 1ns/10ps
module test_adc_parallel_host_port;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_word_mode = 1'b1;
	logic i_conversion_start_n = 1'b1;
	logic i_master_clock_in = 1'b0;
	logic i_auto_sleep = 1'b0;
	logic [11:0] i_conv_result = 12'h000;
	logic [2:0] i_conv_chan = 3'h0;
	logic i_cs_n, i_rd_n, i_wr_n, i_shared_bit8_or_upper_enable, o_shared_bit8;
	logic o_shared_bit8_oe, o_busy, o_track_hold, o_powered, o_ctrl_write;
	logic [7:0] i_data_lines_low, o_data_lines_low, o_data_lines_low_oe;
	logic [2:0] i_data_lines_upper, o_data_lines_upper, o_data_lines_upper_oe;
	logic [11:0] o_control, o_shadow, q, oe;
	int fails = 0;
	int checked = 0;
	int cyc = 0;
	assign oe = {o_data_lines_upper_oe, o_shared_bit8_oe, o_data_lines_low_oe};
	initial forever #2 i_clk = ~i_clk;
	adc_parallel_host_port #(.RES_BITS(12)) adc_parallel_host_port_inst (.*);
	host_model host_model_inst (.i_clk, .i_dev_oe(oe), .o_cs_n(i_cs_n), .o_rd_n(i_rd_n),
		.o_wr_n(i_wr_n), .i_dev({o_data_lines_upper, o_shared_bit8, o_data_lines_low}),
		.o_pins({i_data_lines_upper, i_shared_bit8_or_upper_enable, i_data_lines_low}));
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		if (fails == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic rd(input logic [11:0] e, input logic [11:0] m, input logic [11:0] exp);
		// Byte mode needs the upper enable pin held at a known level
		host_model_inst.xfer(1'b0, i_word_mode ? e : 12'h100, e, q);
		chk(q & m, exp);
		chk(oe, 12'h000);
	endtask
	// Master clock at an eighth of i_clk; a gap after six rises makes it a burst
	task automatic conv(input int gap);
		@(posedge i_clk) i_conversion_start_n <= 1'b0;
		@(posedge i_clk) i_conversion_start_n <= 1'b1;
		for (int k = 0; k < 13; k++)
		begin
			repeat (k == 6 ? gap + 4 : 4) @(posedge i_clk);
			if (k == 0) chk({10'h000, o_busy, o_track_hold}, 12'h003);
			i_master_clock_in <= 1'b1;
			repeat (4) @(posedge i_clk);
			i_master_clock_in <= 1'b0;
		end
		for (int k = 0; k < 9 && o_busy === 1'b1; k++)
			@(posedge i_clk);
		chk({10'h000, o_busy, o_track_hold}, 12'h000);
	endtask
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			fails++;
			close_out();
		end
	end
	initial
	begin
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		host_model_inst.xfer(1'b1, 12'hfff, 12'h8a5, q);
		chk(o_control, 12'h8a5);
		host_model_inst.xfer(1'b1, 12'hfff, 12'h3c6, q);
		chk(o_shadow, 12'h3c6);
		i_conv_result <= 12'hb5e;
		i_conv_chan <= 3'h5;
		conv(0);
		rd(12'h000, 12'hfff, 12'hb5e);
		i_word_mode <= 1'b0;
		rd(12'h100 ^ 12'h100, 12'h0ff, 12'h05e);
		rd(12'h100, 12'h0ff, 12'h05b);
		host_model_inst.xfer(1'b1, 12'h1ff, 12'h034, q);
		host_model_inst.xfer(1'b1, 12'h1ff, 12'h101, q);
		chk(o_shadow, 12'h134);
		i_word_mode <= 1'b1;
		i_conv_result <= 12'h6d2;
		i_auto_sleep <= 1'b1;
		conv(40);
		rd(12'h000, 12'hfff, 12'h6d2);
		chk({11'h000, o_powered}, 12'h000);
		@(posedge i_clk) i_conversion_start_n <= 1'b0;
		@(posedge i_clk) i_conversion_start_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		chk({10'h000, o_powered, o_busy}, 12'h002);
		close_out();
	end
endmodule // test_adc_parallel_host_port
